// ==== rtl/synth_prog_top.sv ====
// Contract
// - Pointer at 0x2c, windows at 0x2d-0x2f.
// - Three 2-bit pointers in bits 5-0.
// - Pointer selects N, M, P, read-only status.
// - Window write advances only that pointer.
// - Window read leaves pointer unchanged.
// - Pointer register reads all three pointers.
// - P bit 7 runs or resets synthesizer.
// - Pixel P bit 6 gates test clock.
// - Status bit 6 shows lock.
// - Output frequency from N, M, P dividers.
// - Select pins pick fixed or programmed.
// - Fixed select makes loop equal dot clock.
// - Dot source selector, resets to external.
// - Return clock bit picks pixel or loop.
`include "synth_prog_defs.svh"

module synth_prog_top
  import synth_prog_pkg::*;
#(
  parameter div6_t FIX0_N = 6'h28,  // Fixed setting for select pattern 00
  parameter div6_t FIX0_M = 6'h01,
  parameter post_t FIX0_P = 2'h0,
  parameter div6_t FIX1_N = 6'h29,  // Fixed setting for select pattern 01
  parameter div6_t FIX1_M = 6'h01,
  parameter post_t FIX1_P = 2'h0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  freq_select_pins_i,
  input  wire logic [2:0]  synth_lock_i,
  input  wire logic        pixel_synth_clk_i,
  output logic      [2:0]  synth_run_enable_o,
  output logic             test_clock_pin_o,
  output logic      [5:0]  pixel_n_o,
  output logic      [5:0]  pixel_m_o,
  output logic      [1:0]  pixel_p_o,
  output logic      [5:0]  memory_n_o,
  output logic      [5:0]  memory_m_o,
  output logic      [1:0]  memory_p_o,
  output logic      [5:0]  loop_n_o,
  output logic      [5:0]  loop_m_o,
  output logic      [1:0]  loop_p_o,
  output logic      [3:0]  dot_clock_source_selector_o,
  output logic             return_clock_source_bit_o
);

  // Extract one two-bit pointer from the packed pointer word
  function automatic logic [1:0] ptr_field(input logic [5:0] word, input logic [2:0] lsb);
    ptr_field = word[lsb +: 2];
  endfunction

  // Pick the settings that a select pattern asks for
  function automatic logic [13:0] pick_cfg(input logic [1:0] sel,
                                           input logic [7:0] n,
                                           input logic [7:0] m,
                                           input logic [7:0] p);
    if (sel[1])
      pick_cfg = {n[5:0], m[5:0], p[1:0]};
    else if (sel[0])
      pick_cfg = {FIX1_N, FIX1_M, FIX1_P};
    else
      pick_cfg = {FIX0_N, FIX0_M, FIX0_P};
  endfunction

  // Bus and register state
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [3:0]  dot_src_r;
  logic [7:0]  mem_loop_ctl_r;

  // Pin synchronisers, two flops each
  logic [1:0]  sel_s1_r;
  logic [1:0]  sel_s2_r;
  logic [2:0]  lock_s1_r;
  logic [2:0]  lock_s2_r;
  logic        pclk_s1_r;
  logic        pclk_s2_r;

  // Output flops
  logic [2:0]  run_r;
  logic        tclk_r;
  logic [13:0] pix_cfg_r;
  logic [13:0] mem_cfg_r;
  logic [13:0] loop_cfg_r;

  // Bank views
  logic [1:0]  ptr_pix;
  logic [1:0]  ptr_mem;
  logic [1:0]  ptr_loop;
  logic [7:0]  rd_pix;
  logic [7:0]  rd_mem;
  logic [7:0]  rd_loop;
  logic [7:0]  n_pix;
  logic [7:0]  m_pix;
  logic [7:0]  p_pix;
  logic [7:0]  n_mem;
  logic [7:0]  m_mem;
  logic [7:0]  p_mem;
  logic [7:0]  n_loop;
  logic [7:0]  m_loop;
  logic [7:0]  p_loop;

  // Access decode: one access per request, ack gates the second cycle
  wire        acc_go   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr_go    = acc_go & wb_we_i & wb_sel_i[0];
  wire        rd_go    = acc_go & ~wb_we_i;
  wire [7:0]  idx      = wb_adr_i[9:2];
  wire        hit_ptr  = (idx == `IDX_POINTER);
  wire        hit_pix  = (idx == `IDX_PIXEL_WIN);
  wire        hit_mem  = (idx == `IDX_MEMORY_WIN);
  wire        hit_loop = (idx == `IDX_LOOP_WIN);
  wire        hit_dot  = (idx == `IDX_DOT_SRC);
  wire        hit_mlc  = (idx == `IDX_MEM_LOOP_CTL);
  wire        ptr_wr   = wr_go & hit_ptr;
  wire [5:0]  ptr_word = {ptr_loop, ptr_mem, ptr_pix};

  // Read mux; unmapped indices read zero, pointer bits 7-6 read zero
  wire [7:0]  rd_byte  = hit_ptr  ? {2'h0, ptr_word} :
                         hit_pix  ? rd_pix  :
                         hit_mem  ? rd_mem  :
                         hit_loop ? rd_loop :
                         hit_dot  ? {4'h0, dot_src_r} :
                         hit_mlc  ? mem_loop_ctl_r : 8'h00;

  // Dividers each bank hands to its synthesizer, done in the analog loop
  wire [13:0] pix_cfg_nxt  = pick_cfg(sel_s2_r, n_pix, m_pix, p_pix);
  wire [13:0] loop_cfg_nxt = sel_s2_r[1] ? {n_loop[5:0], m_loop[5:0], p_loop[1:0]}
                                         : pix_cfg_nxt;
  wire [13:0] mem_cfg_nxt  = {n_mem[5:0], m_mem[5:0], p_mem[1:0]};
  wire [2:0]  run_nxt      = {p_loop[`P_RUN_BIT], p_mem[`P_RUN_BIT],
                              p_pix[`P_RUN_BIT]};
  wire        tclk_nxt     = p_pix[`P_TCLK_BIT] & pclk_s2_r;

  // Three independent synthesizer banks
  synth_bank u_pix (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ptr_load_i (ptr_wr),
    .ptr_val_i  (ptr_field(wb_dat_i[5:0], 3'(`PTR_PIXEL_LSB))),
    .win_wr_i   (wr_go & hit_pix),
    .wdat_i     (wb_dat_i[7:0]),
    .lock_i     (lock_s2_r[0]),
    .ptr_o      (ptr_pix),
    .rdat_o     (rd_pix),
    .n_o        (n_pix),
    .m_o        (m_pix),
    .p_o        (p_pix)
  );

  synth_bank u_mem (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ptr_load_i (ptr_wr),
    .ptr_val_i  (ptr_field(wb_dat_i[5:0], 3'(`PTR_MEMORY_LSB))),
    .win_wr_i   (wr_go & hit_mem),
    .wdat_i     (wb_dat_i[7:0]),
    .lock_i     (lock_s2_r[1]),
    .ptr_o      (ptr_mem),
    .rdat_o     (rd_mem),
    .n_o        (n_mem),
    .m_o        (m_mem),
    .p_o        (p_mem)
  );

  synth_bank u_loop (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ptr_load_i (ptr_wr),
    .ptr_val_i  (ptr_field(wb_dat_i[5:0], 3'(`PTR_LOOP_LSB))),
    .win_wr_i   (wr_go & hit_loop),
    .wdat_i     (wb_dat_i[7:0]),
    .lock_i     (lock_s2_r[2]),
    .ptr_o      (ptr_loop),
    .rdat_o     (rd_loop),
    .n_o        (n_loop),
    .m_o        (m_loop),
    .p_o        (p_loop)
  );

  // Bus slave: one wait state, ack held for exactly one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= acc_go;
      if (rd_go)
        rdat_r <= {24'h00_0000, rd_byte};
    end
  end

  // Clock routing control registers, written only through lane 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dot_src_r      <= `RST_DOT_SRC;
      mem_loop_ctl_r <= `RST_MEM_LOOP_CTL;
    end else begin
      if (wr_go && hit_dot) dot_src_r <= wb_dat_i[3:0];
      if (wr_go && hit_mlc) mem_loop_ctl_r <= wb_dat_i[7:0];
    end
  end

  // Pins come from outside the clock domain; stage one feeds stage two only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_s1_r  <= 2'h0;
      sel_s2_r  <= 2'h0;
      lock_s1_r <= 3'h0;
      lock_s2_r <= 3'h0;
      pclk_s1_r <= 1'b0;
      pclk_s2_r <= 1'b0;
    end else begin
      sel_s1_r  <= freq_select_pins_i;
      sel_s2_r  <= sel_s1_r;
      lock_s1_r <= synth_lock_i;
      lock_s2_r <= lock_s1_r;
      pclk_s1_r <= pixel_synth_clk_i;
      pclk_s2_r <= pclk_s1_r;
    end
  end

  // Output flops; the test pin is a sampled copy, so it only shows
  // synthesizer clocks well below half the register clock rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r      <= 3'h0;
      tclk_r     <= 1'b0;
      pix_cfg_r  <= 14'h0000;
      mem_cfg_r  <= 14'h0000;
      loop_cfg_r <= 14'h0000;
    end else begin
      run_r      <= run_nxt;
      tclk_r     <= tclk_nxt;
      pix_cfg_r  <= pix_cfg_nxt;
      mem_cfg_r  <= mem_cfg_nxt;
      loop_cfg_r <= loop_cfg_nxt;
    end
  end

  // Port drivers
  assign wb_ack_o                    = ack_r;
  assign wb_dat_o                    = rdat_r;
  assign synth_run_enable_o          = run_r;
  assign test_clock_pin_o            = tclk_r;
  assign pixel_n_o                   = pix_cfg_r[13:8];
  assign pixel_m_o                   = pix_cfg_r[7:2];
  assign pixel_p_o                   = pix_cfg_r[1:0];
  assign memory_n_o                  = mem_cfg_r[13:8];
  assign memory_m_o                  = mem_cfg_r[7:2];
  assign memory_p_o                  = mem_cfg_r[1:0];
  assign loop_n_o                    = loop_cfg_r[13:8];
  assign loop_m_o                    = loop_cfg_r[7:2];
  assign loop_p_o                    = loop_cfg_r[1:0];
  assign dot_clock_source_selector_o = dot_src_r;
  assign return_clock_source_bit_o   = mem_loop_ctl_r[`RCLK_SRC_BIT];

  // Checks next to the logic they guard
  a_ack_one_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood for more than one cycle");

  a_ptr_write_load: assert property (@(posedge clk_i) disable iff (rst_i)
    ptr_wr |=> ptr_word == $past(wb_dat_i[5:0]))
    else $error("pointer write did not load all pointers");

  a_pix_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && hit_pix |=> ptr_pix == 2'($past(ptr_pix) + 2'h1)
      && ptr_mem == $past(ptr_mem) && ptr_loop == $past(ptr_loop))
    else $error("pixel window write moved the wrong pointer");

  a_loop_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && hit_loop |=> ptr_loop == 2'($past(ptr_loop) + 2'h1)
      && ptr_pix == $past(ptr_pix))
    else $error("loop window write moved the wrong pointer");

  a_read_holds_ptr: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_go |=> ptr_word == $past(ptr_word))
    else $error("read changed a pointer");

  a_ptr_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_go && hit_ptr |=> wb_ack_o && wb_dat_o == {26'h0, $past(ptr_word)})
    else $error("pointer read returned wrong value");

  a_status_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_go && hit_pix && ptr_pix == 2'h3
      |=> wb_dat_o == {24'h0, 1'b0, $past(lock_s2_r[0]), 6'h00})
    else $error("status read did not show lock");

  a_run_follows_p: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 synth_run_enable_o[0] == $past(p_pix[`P_RUN_BIT]))
    else $error("run enable does not follow P bit 7");

  a_test_clk_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !p_pix[`P_TCLK_BIT] |=> !test_clock_pin_o)
    else $error("test clock pin not held low");

  a_fixed_loop_eq: assert property (@(posedge clk_i) disable iff (rst_i)
    !sel_s2_r[1] |=> loop_cfg_r == pix_cfg_r)
    else $error("loop setting differs from dot clock in fixed mode");

  a_fixed_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_s2_r == 2'h1 |=> pixel_n_o == FIX1_N && pixel_p_o == FIX1_P)
    else $error("fixed pattern 01 not applied");

  a_dot_src_reset: assert property (@(posedge clk_i)
    rst_i |=> dot_clock_source_selector_o == `DOT_SRC_EXT && !return_clock_source_bit_o)
    else $error("clock routing not at reset choice");

  a_mem_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && hit_mem |=> ptr_mem == 2'($past(ptr_mem) + 2'h1)
      && ptr_pix == $past(ptr_pix) && ptr_loop == $past(ptr_loop))
    else $error("memory window write moved the wrong pointer");

  // Only the programmed pattern is checked here; the reset edge would trip a fixed one
  a_prog_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_s2_r[1] |=> pixel_n_o == $past(n_pix[5:0]) && pixel_m_o == $past(m_pix[5:0])
      && pixel_p_o == $past(p_pix[1:0]))
    else $error("programmed pixel setting not applied");

  a_mem_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 memory_n_o == $past(n_mem[5:0]) && memory_m_o == $past(m_mem[5:0])
      && memory_p_o == $past(p_mem[1:0]))
    else $error("memory dividers do not follow their registers");

  a_dot_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && hit_dot |=> dot_clock_source_selector_o == $past(wb_dat_i[3:0]))
    else $error("dot source write not applied");

  a_return_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && hit_mlc |=> return_clock_source_bit_o == $past(wb_dat_i[`RCLK_SRC_BIT]))
    else $error("return clock bit write not applied");

endmodule // synth_prog_top

// ==== rtl/synth_prog_defs.svh ====
`ifndef SYNTH_PROG_DEFS_SVH
`define SYNTH_PROG_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_POINTER      8'h2c
`define IDX_PIXEL_WIN    8'h2d
`define IDX_MEMORY_WIN   8'h2e
`define IDX_LOOP_WIN     8'h2f
`define IDX_DOT_SRC      8'h1a
`define IDX_MEM_LOOP_CTL 8'h39

// Pointer field positions inside the pointer register
`define PTR_PIXEL_LSB    0
`define PTR_MEMORY_LSB   2
`define PTR_LOOP_LSB     4

// Bit positions inside value, status and control words
`define P_RUN_BIT        7
`define P_TCLK_BIT       6
`define STAT_LOCK_BIT    6
`define RCLK_SRC_BIT     5

// Dot clock source codes
`define DOT_SRC_PIXEL    4'h5
`define DOT_SRC_EXT      4'h7

// Reset values
`define RST_POINTER      6'h00
`define RST_N_VALUE      8'hc0
`define RST_M_VALUE      8'h00
`define RST_P_VALUE      8'h30
`define RST_DOT_SRC      4'h7
`define RST_MEM_LOOP_CTL 8'h18

`endif

// ==== rtl/synth_prog_pkg.sv ====
package synth_prog_pkg;
  // What a two-bit synthesizer pointer routes its window to
  typedef enum logic [1:0] {
    SEL_N_VALUE = 2'h0,
    SEL_M_VALUE = 2'h1,
    SEL_P_VALUE = 2'h2,
    SEL_STATUS  = 2'h3
  } value_sel_t;

  // Divider settings handed to one synthesizer
  typedef logic [5:0] div6_t;
  typedef logic [1:0] post_t;
endpackage

// ==== rtl/synth_bank.sv ====
`include "synth_prog_defs.svh"

// One synthesizer: pointer plus N, M, P value registers and status view
module synth_bank
  import synth_prog_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ptr_load_i,
  input  wire logic [1:0] ptr_val_i,
  input  wire logic       win_wr_i,
  input  wire logic [7:0] wdat_i,
  input  wire logic       lock_i,
  output logic      [1:0] ptr_o,
  output logic      [7:0] rdat_o,
  output logic      [7:0] n_o,
  output logic      [7:0] m_o,
  output logic      [7:0] p_o
);

  value_sel_t ptr_r;
  value_sel_t ptr_nxt;
  logic [7:0] n_r;
  logic [7:0] m_r;
  logic [7:0] p_r;
  logic [7:0] status_w;

  // Load wins over advance, though both cannot hit in one access
  assign ptr_nxt = ptr_load_i ? value_sel_t'(ptr_val_i) :
                   win_wr_i   ? value_sel_t'(ptr_r + 2'h1) : ptr_r;

  // Only the lock bit means anything; test bits read zero
  assign status_w = {1'b0, lock_i, 6'h00};

  // Window read routing by pointer
  assign rdat_o = (ptr_r == SEL_N_VALUE) ? n_r :
                  (ptr_r == SEL_M_VALUE) ? m_r :
                  (ptr_r == SEL_P_VALUE) ? p_r : status_w;

  // Pointer and value registers; status writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_r <= value_sel_t'(2'(`RST_POINTER));
      n_r   <= `RST_N_VALUE;
      m_r   <= `RST_M_VALUE;
      p_r   <= `RST_P_VALUE;
    end else begin
      ptr_r <= ptr_nxt;
      if (win_wr_i && ptr_r == SEL_N_VALUE) n_r <= wdat_i;
      if (win_wr_i && ptr_r == SEL_M_VALUE) m_r <= wdat_i;
      if (win_wr_i && ptr_r == SEL_P_VALUE) p_r <= wdat_i;
    end
  end

  assign ptr_o = ptr_r;
  assign n_o   = n_r;
  assign m_o   = m_r;
  assign p_o   = p_r;

  a_status_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    win_wr_i && ptr_r == SEL_STATUS |=> n_r == $past(n_r) && m_r == $past(m_r)
      && p_r == $past(p_r))
    else $error("status write changed a value register");

endmodule // synth_bank

// ==== verif/host_bus_model.sv ====
`include "synth_prog_defs.svh"

// Host software seen from the register bus: classic Wishbone master
module host_bus_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic      [9:0]  wb_adr_o,
  output logic      [3:0]  wb_sel_o,
  output logic      [31:0] wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 10'h000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // One classic cycle; entered just after a rising edge, waits as long as the slave needs
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd_v);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_sel_o <= 4'h1;
    wb_adr_o <= {idx, 2'b00};
    wb_dat_o <= {24'h0, wd};
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1) @(posedge clk_i);
    rd_v = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released lines show the inverse so stale values are never mistaken for live ones
    wb_adr_o <= ~wb_adr_o;
    wb_dat_o <= ~wb_dat_o;
    wb_sel_o <= ~wb_sel_o;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    xfer(1'b1, idx, wd, d);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    xfer(1'b0, idx, 8'h00, v);
  endtask

  // Clear only this synthesizer's pointer, then N, M, P in three writes
  task automatic prog(input int b, input logic [5:0] n, input logic [5:0] m,
                      input logic [1:0] p, input logic en);
    logic [7:0] ptr;
    rd(`IDX_POINTER, ptr);
    wr(`IDX_POINTER, ptr & ~(8'h03 << (2 * b)));
    wr(8'(`IDX_PIXEL_WIN + b), {2'b11, n});
    wr(8'(`IDX_PIXEL_WIN + b), {2'b00, m});
    wr(8'(`IDX_PIXEL_WIN + b), {en, 1'b0, 4'hc, p});
  endtask
endmodule // host_bus_model

// ==== verif/pll_program_port_and_freq_select_bench.sv ====
`include "synth_prog_defs.svh"

module pll_program_port_and_freq_select_bench
  import synth_prog_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam div6_t FX0N = 6'h2b;
  localparam div6_t FX0M = 6'h03;
  localparam post_t FX0P = 2'h1;
  localparam div6_t FX1N = 6'h30;
  localparam div6_t FX1M = 6'h05;
  localparam post_t FX1P = 2'h2;

  int          seed, fail_count, tests_run, cycles, hi;
  logic        clk_i, rst_i, cyc, stb, we, ack, tclk_o, ret_o;
  logic [9:0]  adr;
  logic [3:0]  sel, dot_o;
  logic [31:0] wdat, rdat;
  logic [1:0]  pins, pp, mp, lp;
  logic [2:0]  lock, run_o;
  logic [2:0]  pdiv = 3'h0;
  logic [5:0]  pn, pm, mn, mm, ln, lm;
  logic [7:0]  v, w, ptr_exp;
  logic [5:0]  nv [3];
  logic [5:0]  mv [3];
  logic [1:0]  pv [3];
  logic        ev [3];
  logic [13:0] bank_q [3];

  // Divider outputs of each bank, gathered for indexed checks
  assign bank_q[0] = {pn, pm, pp};
  assign bank_q[1] = {mn, mm, mp};
  assign bank_q[2] = {ln, lm, lp};

  synth_prog_top #(.FIX0_N(FX0N), .FIX0_M(FX0M), .FIX0_P(FX0P),
    .FIX1_N(FX1N), .FIX1_M(FX1M), .FIX1_P(FX1P)) synth_prog_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .freq_select_pins_i(pins), .synth_lock_i(lock), .pixel_synth_clk_i(pdiv[2]),
    .synth_run_enable_o(run_o), .test_clock_pin_o(tclk_o),
    .pixel_n_o(pn), .pixel_m_o(pm), .pixel_p_o(pp),
    .memory_n_o(mn), .memory_m_o(mm), .memory_p_o(mp),
    .loop_n_o(ln), .loop_m_o(lm), .loop_p_o(lp),
    .dot_clock_source_selector_o(dot_o), .return_clock_source_bit_o(ret_o));

  host_bus_model host_bus_model_inst (
    .clk_i(clk_i), .wb_dat_i(rdat), .wb_ack_i(ack), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Slow stand-in synth clock so the synchronised test pin can follow it
  always @(posedge clk_i) pdiv <= pdiv + 3'h1;

  // Hang guard: far above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end

  function automatic logic [7:0] set_field(input logic [7:0] ptr, input int b,
                                           input logic [1:0] f);
    logic [7:0] r;
    r = ptr;
    r[2 * b +: 2] = f;
    return r;
  endfunction

  // What a window shows for each pointer value
  function automatic logic [7:0] win_word(input int b, input logic [1:0] k);
    case (k)
      2'h0:    return {2'b11, nv[b]};
      2'h1:    return {2'b00, mv[b]};
      2'h2:    return {ev[b], 1'b0, 4'hc, pv[b]};
      default: return {1'b0, lock[b], 6'h00};
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count = fail_count + 1;
    end
  endtask

  // Let registered outputs land before looking at them
  task automatic settle;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    seed = 86;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    rst_i = 1'b1;
    pins = 2'b10;
    lock = 3'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    lock <= 3'($random(seed));
    host_bus_model_inst.rd(`IDX_DOT_SRC, v);
    chk(v, 8'h07);
    host_bus_model_inst.rd(`IDX_MEM_LOOP_CTL, v);
    chk(v, 8'h18);
    host_bus_model_inst.rd(8'h00, v);
    chk(v, 8'h00);
    chk({run_o, tclk_o, dot_o, ret_o}, {3'h0, 1'b0, 4'h7, 1'b0});
    // Whole-register pointer loads with junk in the top bits
    repeat (4) begin
      w = 8'($random(seed));
      host_bus_model_inst.wr(`IDX_POINTER, w);
      host_bus_model_inst.rd(`IDX_POINTER, v);
      chk(v, {2'b00, w[5:0]});
    end
    ptr_exp = {2'b00, w[5:0]};
    for (int b = 0; b < 3; b++) begin
      nv[b] = 6'(40 + {$random(seed)} % 23);
      if (b == 0) nv[b] = 6'h3e;
      mv[b] = 6'(1 + {$random(seed)} % 62);
      pv[b] = 2'($random(seed));
      ev[b] = 1'($random(seed));
      host_bus_model_inst.prog(b, nv[b], mv[b], pv[b], ev[b]);
      ptr_exp = set_field(ptr_exp, b, 2'h3);
      host_bus_model_inst.rd(`IDX_POINTER, v);
      chk(v, ptr_exp);
      repeat (2) begin
        host_bus_model_inst.rd(8'(`IDX_PIXEL_WIN + b), v);
        chk(v, win_word(b, 2'h3));
      end
      host_bus_model_inst.rd(`IDX_POINTER, v);
      chk(v, ptr_exp);
      for (int k = 0; k < 3; k++) begin
        ptr_exp = set_field(ptr_exp, b, 2'(k));
        host_bus_model_inst.wr(`IDX_POINTER, ptr_exp);
        host_bus_model_inst.rd(8'(`IDX_PIXEL_WIN + b), v);
        chk(v, win_word(b, 2'(k)));
      end
      settle();
      chk(run_o[b], ev[b]);
      chk(bank_q[b], {nv[b], mv[b], pv[b]});
      @(posedge clk_i);
    end
    // Test pin stays low while its enable is clear, then follows the synth clock
    hi = 0;
    repeat (64) begin
      @(posedge clk_i);
      #1;
      hi = hi + int'(tclk_o);
      chk(tclk_o, 1'b0);
    end
    chk(hi, 0);
    @(posedge clk_i);
    host_bus_model_inst.wr(`IDX_PIXEL_WIN, {ev[0], 1'b1, 4'hc, pv[0]});
    hi = 0;
    repeat (64) begin
      @(posedge clk_i);
      #1;
      hi = hi + int'(tclk_o);
      chk(tclk_o !== 1'bx, 1'b1);
    end
    chk(hi > 8 && hi < 56, 1'b1);
    // Fixed selections drive pixel and loop alike
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_i);
      pins <= 2'(s);
      settle();
      chk({pn, pm, pp}, (s == 0) ? {FX0N, FX0M, FX0P} : {FX1N, FX1M, FX1P});
      chk({ln, lm, lp}, (s == 0) ? {FX0N, FX0M, FX0P} : {FX1N, FX1M, FX1P});
    end
    @(posedge clk_i);
    pins <= 2'b10;
    settle();
    chk({pn, pm, pp, ln, lm, lp}, {nv[0], mv[0], pv[0], nv[2], mv[2], pv[2]});
    // First VGA setup: pixel synth as dot source, loop synth on return pin
    @(posedge clk_i);
    host_bus_model_inst.wr(`IDX_DOT_SRC, 8'h05);
    host_bus_model_inst.wr(`IDX_MEM_LOOP_CTL, 8'h38);
    settle();
    chk({dot_o, ret_o}, {4'h5, 1'b1});
    // Mid-run reset must put routing back to its power-up choice
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    chk({dot_o, ret_o, run_o, tclk_o}, {4'h7, 1'b0, 3'h0, 1'b0});
    // Second VGA setup: external clock, pixel synth returned, loop synth stopped
    @(posedge clk_i);
    host_bus_model_inst.wr(`IDX_DOT_SRC, 8'h07);
    host_bus_model_inst.wr(`IDX_MEM_LOOP_CTL, 8'h18);
    // Reset cleared the loop pointer, so load it with the P value first
    host_bus_model_inst.wr(`IDX_POINTER, 8'h20);
    host_bus_model_inst.wr(`IDX_LOOP_WIN, {1'b0, 1'b0, 4'hc, pv[2]});
    settle();
    chk({dot_o, ret_o, run_o[2]}, {4'h7, 1'b0, 1'b0});
    @(posedge clk_i);
    host_bus_model_inst.rd(`IDX_DOT_SRC, v);
    chk(v, 8'h07);
    give_verdict();
  end
endmodule // pll_program_port_and_freq_select_bench
